// file: src/acclu_pkg.sv
package acclu_pkg;
    // datapath widths
    localparam int ACCLU_ACC_W = 32;
    localparam int ACCLU_WORD_W = 16;
    localparam int ACCLU_ADDR_W = 16;
    localparam int ACCLU_CNT_W = 6;
    localparam int ACCLU_OCT_DIGITS = 6;
    localparam int ACCLU_STACK_DEPTH = 8;
    // values after reset
    localparam logic [31:0] ACCLU_ACC_RST = 32'h0000_0000;
    localparam logic [15:0] ACCLU_ADDR_RST = 16'h0000;
    localparam logic [5:0] ACCLU_CNT_RST = 6'h01;
    // bit field length limits
    localparam logic [5:0] ACCLU_MIN_BITS = 6'h01;
    localparam logic [5:0] ACCLU_MAX_BITS = 6'h20;
    // word step between the two halves of a double load
    localparam logic [15:0] ACCLU_WORD_STEP = 16'h0001;

    typedef enum logic [1:0] {
        load_double_op = 2'h0,
        load_bit_field_op = 2'h1,
        load_octal_address_op = 2'h2,
        load_indexed_op = 2'h3
    } acclu_op_t;

    typedef enum logic [3:0] {
        ACCLU_IDLE = 4'h1,
        ACCLU_WAIT_LO = 4'h2,
        ACCLU_WAIT_HI = 4'h4,
        ACCLU_WAIT_BITS = 4'h8
    } acclu_state_t;
endpackage : acclu_pkg

// file: src/acclu_octal_conv.sv
`timescale 1ns/1ps
// packs octal digits (one per nibble, digit 0 lowest) into a binary value
module acclu_octal_conv
    import acclu_pkg::*;
#(
    parameter int DIGITS = ACCLU_OCT_DIGITS
) (
    input wire logic [4*DIGITS-1:0] octal_digits,
    output logic [15:0] binary_value
);
    logic [3*DIGITS-1:0] packed_bits;

    // each octal digit is exactly three binary bits; nibble bit 3 is ignored
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : g_digit
            assign packed_bits[3*g +: 3] = octal_digits[4*g +: 3];
        end
    endgenerate

    // six digits give 18 bits; the top two fall outside the 16-bit result
    assign binary_value = packed_bits[15:0];
endmodule : acclu_octal_conv

// file: src/acclu_load_unit.sv
// Operation
// RL1 - double load puts a full 32-bit operand from two words or constant
// RL2 - first memory word fills bits 15..0, next word fills bits 31..16
// RL3 - zero flag set when newly loaded accumulator is zero, else cleared
// RL4 - a load pushes the previous accumulator onto stack level one first
// RL5 - bit field load copies 1 to 32 consecutive bits from start address
// RL6 - first bit goes to bit 0; bits above the count are forced zero
// RL7 - address load converts octal operand to binary, loaded as 16 bits
// RL8 - indexed load adds stack level one offset to the source address
// RL9 - indexed load puts read word in bits 15..0, clears bits 31..16
// RL10 - stack level one offset is used as plain binary, never as octal
// RL11 - program gives address parameters in octal notation
`timescale 1ns/1ps
module acclu_load_unit
    import acclu_pkg::*;
#(
    parameter int STACK_DEPTH = ACCLU_STACK_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire acclu_op_t cmd_op,
    input wire logic cmd_use_const,
    input wire logic [15:0] cmd_addr,
    input wire logic [31:0] cmd_const,
    input wire logic [4*ACCLU_OCT_DIGITS-1:0] cmd_octal,
    input wire logic [5:0] cmd_bit_count,
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic bit_req,
    output logic [15:0] bit_addr,
    input wire logic bit_ack,
    input wire logic [31:0] bit_rdata,
    output logic [31:0] acc,
    output logic acc_zero_flag,
    output logic load_done,
    output logic [31:0] stack_level1
);
    acclu_state_t state;
    acclu_op_t cur_op;
    logic [5:0] bit_count;
    logic [15:0] octal_value;
    logic [31:0] field_mask;
    logic [5:0] next_count;
    logic accept;
    logic commit;
    logic [31:0] next_acc;
    logic [31:0] stack [STACK_DEPTH];

    acclu_octal_conv #(
        .DIGITS(ACCLU_OCT_DIGITS)
    ) u_octal (
        .octal_digits(cmd_octal),
        .binary_value(octal_value)
    );

    // a new command is taken only while nothing is outstanding
    assign cmd_ready = (state == ACCLU_IDLE);
    assign accept = cmd_valid && cmd_ready;
    assign mem_req = (state == ACCLU_WAIT_LO) || (state == ACCLU_WAIT_HI);
    assign bit_req = (state == ACCLU_WAIT_BITS);
    assign stack_level1 = stack[0];

    // lengths outside 1..32 are clamped rather than refused
    always_comb begin
        next_count = cmd_bit_count;
        if (cmd_bit_count < ACCLU_MIN_BITS) begin
            next_count = ACCLU_MIN_BITS;
        end else if (cmd_bit_count > ACCLU_MAX_BITS) begin
            next_count = ACCLU_MAX_BITS;
        end
    end

    // ones in the low bit_count positions
    always_comb begin
        field_mask = '0;
        for (int i = 0; i < ACCLU_ACC_W; i++) begin
            field_mask[i] = (i < int'(bit_count));
        end
    end

    // value and moment of every completed accumulator load
    always_comb begin
        commit = 1'b0;
        next_acc = acc;
        if (accept && cmd_op == load_double_op && cmd_use_const) begin
            // RL1 constant double load
            commit = 1'b1;
            next_acc = cmd_const;
        end else if (accept && cmd_op == load_octal_address_op) begin
            // RL7 octal to binary
            commit = 1'b1;
            next_acc = {16'h0000, octal_value};
        end else if (state == ACCLU_WAIT_LO && mem_ack && cur_op == load_indexed_op) begin
            // RL9 upper half cleared
            commit = 1'b1;
            next_acc = {16'h0000, mem_rdata};
        end else if (state == ACCLU_WAIT_HI && mem_ack) begin
            // RL2 high word on top
            commit = 1'b1;
            next_acc = {mem_rdata, acc[15:0]};
        end else if (state == ACCLU_WAIT_BITS && bit_ack) begin
            // RL6 zero above count
            commit = 1'b1;
            next_acc = bit_rdata & field_mask;
        end
    end

    // sequencing of memory reads
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ACCLU_IDLE;
            cur_op <= load_double_op;
            bit_count <= ACCLU_CNT_RST;
        end else begin
            unique case (state)
                ACCLU_IDLE: begin
                    if (accept) begin
                        cur_op <= cmd_op;
                        bit_count <= next_count;
                        if (cmd_op == load_bit_field_op) begin
                            state <= ACCLU_WAIT_BITS;
                        end else if (cmd_op == load_indexed_op) begin
                            state <= ACCLU_WAIT_LO;
                        end else if (cmd_op == load_double_op && !cmd_use_const) begin
                            state <= ACCLU_WAIT_LO;
                        end
                    end
                end
                ACCLU_WAIT_LO: begin
                    if (mem_ack) begin
                        state <= (cur_op == load_indexed_op) ? ACCLU_IDLE : ACCLU_WAIT_HI;
                    end
                end
                ACCLU_WAIT_HI: begin
                    if (mem_ack) begin
                        state <= ACCLU_IDLE;
                    end
                end
                ACCLU_WAIT_BITS: begin
                    if (bit_ack) begin
                        state <= ACCLU_IDLE;
                    end
                end
            endcase
        end
    end

    // read addresses are held steady while a request is open
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_addr <= ACCLU_ADDR_RST;
            bit_addr <= ACCLU_ADDR_RST;
        end else if (accept) begin
            // RL8 RL10 binary offset add
            if (cmd_op == load_indexed_op) begin
                mem_addr <= cmd_addr + acc[15:0];
            end else begin
                mem_addr <= cmd_addr;
            end
            // RL5 field start address
            bit_addr <= cmd_addr;
        end else if (state == ACCLU_WAIT_LO && mem_ack) begin
            // RL2 next word address
            mem_addr <= mem_addr + ACCLU_WORD_STEP;
        end
    end

    // low half of a memory double load lands first
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc <= ACCLU_ACC_RST;
        end else if (commit) begin
            acc <= next_acc;
        end else if (state == ACCLU_WAIT_LO && mem_ack) begin
            // RL1 RL2 low word first
            acc <= {16'h0000, mem_rdata};
        end
    end

    // flag follows only completed loads, not the half-loaded double value
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_zero_flag <= 1'b1;
            load_done <= 1'b0;
        end else begin
            load_done <= commit;
            if (commit) begin
                // RL3 zero flag update
                acc_zero_flag <= (next_acc == ACCLU_ACC_RST);
            end
        end
    end

    // accumulator stack; the oldest level falls off the bottom
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= ACCLU_ACC_RST;
            end
        end else if (accept) begin
            // RL4 push previous value
            stack[0] <= acc;
            for (int i = 1; i < STACK_DEPTH; i++) begin
                stack[i] <= stack[i-1];
            end
        end
    end

    sequence dbl_mem_start_s;
        accept && cmd_op == load_double_op && !cmd_use_const;
    endsequence

    sequence lo_taken_s;
        state == ACCLU_WAIT_LO && mem_ack && cur_op == load_double_op;
    endsequence

    // half-loaded value: no completion pulse and no flag change yet
    sequence lo_landed_s;
        mem_addr == $past(mem_addr) + 16'h0001 && acc[15:0] == $past(mem_rdata)
        && acc[31:16] == 16'h0000 && !load_done && $stable(acc_zero_flag);
    endsequence

    zero_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // RL3
        load_done |-> acc_zero_flag == (acc == 32'h0000_0000))
        else $error("zero flag does not match accumulator");

    dbl_order_a: assert property (@(posedge clk) disable iff (sys_rst) // RL2
        lo_taken_s |=> lo_landed_s)
        else $error("double load low word or next address wrong");

    dbl_start_a: assert property (@(posedge clk) disable iff (sys_rst) // RL1
        dbl_mem_start_s |=> mem_req && !cmd_ready && mem_addr == $past(cmd_addr))
        else $error("double load first read request wrong");

    dbl_high_a: assert property (@(posedge clk) disable iff (sys_rst) // RL2
        state == ACCLU_WAIT_HI && mem_ack
        |=> load_done && acc[31:16] == $past(mem_rdata) && acc[15:0] == $past(acc[15:0]))
        else $error("double load high word wrong");

    dbl_const_a: assert property (@(posedge clk) disable iff (sys_rst) // RL1
        accept && cmd_op == load_double_op && cmd_use_const
        |=> acc == $past(cmd_const) && load_done && cmd_ready)
        else $error("constant double load wrong");

    push_a: assert property (@(posedge clk) disable iff (sys_rst) // RL4
        accept |=> stack_level1 == $past(acc) && stack[1] == $past(stack[0]))
        else $error("previous accumulator not pushed");

    field_mask_a: assert property (@(posedge clk) disable iff (sys_rst) // RL6
        state == ACCLU_WAIT_BITS && bit_ack
        |=> (acc & ~field_mask) == 32'h0000_0000 && acc[0] == $past(bit_rdata[0]))
        else $error("bit field above count not zero");

    field_addr_a: assert property (@(posedge clk) disable iff (sys_rst) // RL5
        accept && cmd_op == load_bit_field_op
        |=> bit_req && bit_addr == $past(cmd_addr) && bit_count >= 6'h01
        && bit_count <= 6'h20)
        else $error("bit field request wrong");

    idx_addr_a: assert property (@(posedge clk) disable iff (sys_rst) // RL8
        accept && cmd_op == load_indexed_op
        |=> mem_req && mem_addr == $past(cmd_addr) + stack_level1[15:0])
        else $error("indexed address wrong");

    idx_word_a: assert property (@(posedge clk) disable iff (sys_rst) // RL9
        state == ACCLU_WAIT_LO && mem_ack && cur_op == load_indexed_op
        |=> acc == {16'h0000, $past(mem_rdata)} && load_done)
        else $error("indexed load result wrong");

    octal_a: assert property (@(posedge clk) disable iff (sys_rst) // RL7
        accept && cmd_op == load_octal_address_op
        |=> acc[31:16] == 16'h0000 && acc[2:0] == $past(cmd_octal[2:0])
        && acc[5:3] == $past(cmd_octal[6:4]))
        else $error("octal conversion wrong");
endmodule : acclu_load_unit

// file: verification/acclu_mem_model.sv
`timescale 1ns/1ps
// far side: data word memory and discrete bit memory with adjustable latency
module acclu_mem_model
    import acclu_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] slow,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [15:0] mem_rdata,
    input wire logic bit_req,
    input wire logic [15:0] bit_addr,
    output logic bit_ack,
    output logic [31:0] bit_rdata
);
    logic [3:0] mcnt = 4'h0;
    logic [3:0] bcnt = 4'h0;
    initial begin
        mem_ack = 1'h0;
        mem_rdata = 16'h0000;
        bit_ack = 1'h0;
        bit_rdata = 32'h0000_0000;
    end
    // word answer after slow idle cycles; data inverts every cycle between answers so data one cycle stale never matches
    always @(posedge clk) begin
        if (mem_req && !mem_ack && mcnt >= slow) begin
            mem_ack <= 1'h1;
            mem_rdata <= {mem_addr[7:0] ^ 8'h5A, mem_addr[15:8]};
            mcnt <= 4'h0;
        end else begin
            mem_ack <= 1'h0;
            mem_rdata <= ~mem_rdata;
            mcnt <= (mem_req && !mem_ack) ? mcnt + 4'h1 : 4'h0;
        end
    end
    // bit answer: bit i stands for the discrete at bit_addr plus i
    always @(posedge clk) begin
        if (bit_req && !bit_ack && bcnt >= slow) begin
            bit_ack <= 1'h1;
            bit_rdata <= {~bit_addr, bit_addr ^ 16'h3C3C};
            bcnt <= 4'h0;
        end else begin
            bit_ack <= 1'h0;
            bit_rdata <= ~bit_rdata;
            bcnt <= (bit_req && !bit_ack) ? bcnt + 4'h1 : 4'h0;
        end
    end
endmodule : acclu_mem_model

// file: verification/acclu_load_unit_bench.sv
`timescale 1ns/1ps
module acclu_load_unit_bench import acclu_pkg::*;;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic cmd_valid = 1'h0;
    logic cmd_ready, mem_req, mem_ack, bit_req, bit_ack, acc_zero_flag, load_done;
    acclu_op_t cmd_op = load_double_op;
    logic cmd_use_const = 1'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [31:0] cmd_const = 32'h0000_0000;
    logic [23:0] cmd_octal = 24'h000000;
    logic [5:0] cmd_bit_count = 6'h01;
    logic [15:0] mem_addr, mem_rdata, bit_addr;
    logic [31:0] bit_rdata, acc, stack_level1;
    logic [3:0] slow = 4'h0;
    logic [31:0] prev = 32'h0000_0000;
    int error_cnt = 0;
    int compares = 0;

    always #2.5 clk = ~clk;

    acclu_load_unit uut (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_use_const(cmd_use_const),
        .cmd_addr(cmd_addr), .cmd_const(cmd_const), .cmd_octal(cmd_octal),
        .cmd_bit_count(cmd_bit_count), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bit_req(bit_req), .bit_addr(bit_addr),
        .bit_ack(bit_ack), .bit_rdata(bit_rdata), .acc(acc), .acc_zero_flag(acc_zero_flag),
        .load_done(load_done), .stack_level1(stack_level1));
    acclu_mem_model far_side (.clk(clk), .slow(slow), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bit_req(bit_req),
        .bit_addr(bit_addr), .bit_ack(bit_ack), .bit_rdata(bit_rdata));

    // expected memory contents, written independently of the far side model
    function automatic logic [15:0] mw(input logic [15:0] a);
        return {a[7:0] ^ 8'h5A, a[15:8]};
    endfunction : mw
    function automatic logic [31:0] bw(input logic [15:0] a, input logic [5:0] n);
        return {~a, a ^ 16'h3C3C} & ((n >= 6'h20) ? 32'hFFFF_FFFF : (32'h1 << n) - 32'h1);
    endfunction : bw

    task automatic close_out;
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one whole load: offer, wait for completion, judge acc, flag and pushed value
    task automatic do_load(input acclu_op_t op, input logic uc, input logic [15:0] a,
            input logic [31:0] k, input logic [23:0] oc, input logic [5:0] n,
            input logic [31:0] exp);
        int i;
        i = 0;
        while (cmd_ready !== 1'h1 && i < 40) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i >= 40) begin
            error_cnt++;
            $display("wrong value cmd_ready expected 1 seen none");
            close_out();
        end
        cmd_op = op;
        cmd_use_const = uc;
        cmd_addr = a;
        cmd_const = k;
        cmd_octal = oc;
        cmd_bit_count = n;
        cmd_valid = 1'h1;
        @(posedge clk);
        #1;
        cmd_valid = 1'h0;
        // busy right after the take unless the load already finished in that edge
        chk("cmd_ready", {31'h0, load_done}, {31'h0, cmd_ready});
        while (load_done !== 1'h1 && i < 80) begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i >= 80) begin
            error_cnt++;
            $display("wrong value load_done expected 1 seen none");
            close_out();
        end
        chk("acc", exp, acc);
        chk("acc_zero_flag", {31'h0, exp == 32'h0}, {31'h0, acc_zero_flag});
        chk("stack_level1", prev, stack_level1);
        chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
        prev = exp;
        @(posedge clk);
        #1;
        chk("load_done", 32'h0, {31'h0, load_done});
    endtask : do_load

    task automatic sc_double;
        do_load(load_double_op, 1'h1, 16'h0000, 32'hDEAD_BEEF, 24'h0, 6'h01, 32'hDEAD_BEEF);
        do_load(load_double_op, 1'h1, 16'h0000, 32'h0, 24'h0, 6'h01, 32'h0);
        do_load(load_double_op, 1'h0, 16'h0100, 32'h0, 24'h0, 6'h01,
            {mw(16'h0101), mw(16'h0100)});
        slow = 4'h3;
        do_load(load_double_op, 1'h0, 16'hFFFF, 32'h0, 24'h0, 6'h01,
            {mw(16'h0000), mw(16'hFFFF)});
        slow = 4'h0;
    endtask : sc_double

    // field lengths at both ends of the range
    task automatic sc_field;
        logic [5:0] cnts [5] = '{6'h01, 6'h07, 6'h10, 6'h1F, 6'h20};
        for (int j = 0; j < 5; j++) begin
            slow = 4'(j);
            do_load(load_bit_field_op, 1'h0, 16'h0040 + 16'(j), 32'h0, 24'h0, cnts[j],
                bw(16'h0040 + 16'(j), cnts[j]));
        end
        slow = 4'h0;
    endtask : sc_field

    task automatic sc_octal;
        do_load(load_octal_address_op, 1'h0, 16'h0, 32'h0, 24'h040400, 6'h01, 32'h4100);
        do_load(load_octal_address_op, 1'h0, 16'h0, 32'h0, 24'h177777, 6'h01, 32'hFFFF);
        do_load(load_octal_address_op, 1'h0, 16'h0, 32'h0, 24'h000000, 6'h01, 32'h0);
    endtask : sc_octal

    // indexed reads; base 16'h0308 is octal 1410 given by the program
    task automatic sc_index;
        do_load(load_octal_address_op, 1'h0, 16'h0, 32'h0, 24'h000025, 6'h01, 32'h15);
        slow = 4'h2;
        do_load(load_indexed_op, 1'h0, 16'h0308, 32'h0, 24'h0, 6'h01,
            {16'h0, mw(16'h031D)});
        do_load(load_double_op, 1'h1, 16'h0, 32'hFFFF_0010, 24'h0, 6'h01, 32'hFFFF_0010);
        do_load(load_indexed_op, 1'h0, 16'h0300, 32'h0, 24'h0, 6'h01,
            {16'h0, mw(16'h0310)});
        slow = 4'h0;
    endtask : sc_index

    // main sequence: reset, state after reset, then every load form
    initial begin
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'h0;
        chk("acc", 32'h0, acc);
        chk("acc_zero_flag", 32'h1, {31'h0, acc_zero_flag});
        sc_double();
        sc_field();
        sc_octal();
        sc_index();
        close_out();
    end
endmodule : acclu_load_unit_bench
